// ### dmpc_contacts.sv
// Model of the external contacts and the fix trigger switch
`default_nettype none
module dmpc_contacts (
  input wire logic i_clk,
  input wire logic [4:0] i_closed,
  input wire logic i_press,
  input wire logic [4:0] i_pu_en,
  input wire logic [4:0] i_o,
  input wire logic [4:0] i_oe,
  output logic [4:0] o_lvl,
  output logic o_trig_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] drift_q = 5'h00;
  // An undriven line without pull-up has no defined level, so it wanders
  always_ff @(posedge i_clk) begin
    drift_q <= ~drift_q;
  end
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (i_oe[i])
        o_lvl[i] = i_o[i];
      else if (i_closed[i])
        o_lvl[i] = 1'h0;
      else if (i_pu_en[i])
        o_lvl[i] = 1'h1;
      else
        o_lvl[i] = drift_q[i];
    end
  end
  // Trigger line idles high through its pull-up; a press grounds it
  assign o_trig_n = ~i_press;
endmodule : dmpc_contacts
`default_nettype wire

// ### dmpc_defs.svh
// Constants for the discrete monitor and power cycler
`ifndef DMPC_DEFS_SVH
`define DMPC_DEFS_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define DMPC_CLK_HZ 100_000_000
`define DMPC_SAMPLE_S 1
`define DMPC_SEC_CYC (`DMPC_CLK_HZ * `DMPC_SAMPLE_S)
`define DMPC_TIME_MS 1
`define DMPC_MS_CYC (`DMPC_CLK_HZ / 1000 * `DMPC_TIME_MS)

// ----------------------------------------------------------------------
// Discrete lines
// ----------------------------------------------------------------------
`define DMPC_NLINES 5
`define DMPC_RSVD_IDX 2
`define DMPC_FIFTH_IDX 4

// ----------------------------------------------------------------------
// Power cycling and triggered fix
// ----------------------------------------------------------------------
`define DMPC_PCT_FULL 7'h64
// Typical setup: 200 ms on in each second, 20 percent
`define DMPC_ON_MS_TYP 16'h00c8
`define DMPC_FRAC_TYP 7'h14
`define DMPC_FIX_ACT_S 20
`define DMPC_REFRESH_S 1800

`endif

// ### dmpc_pkg.sv
// Types shared by the discrete monitor and power cycler
`default_nettype none
package dmpc_pkg;
  typedef enum logic [1:0] {
    CYC_ON = 2'b00,
    CYC_NAV = 2'b01,
    CYC_SLEEP = 2'b10
  } dmpc_cyc_st_e;

  typedef enum logic [2:0] {
    FIX_ACQ = 3'b000,
    FIX_SLEEP = 3'b001,
    FIX_TRIG = 3'b010,
    FIX_REFR = 3'b011
  } dmpc_fix_st_e;

  typedef struct packed {
    dmpc_cyc_st_e st;
    logic [15:0] ms_cnt;
    logic [23:0] acc;
    logic rf;
    logic awake;
    logic wake;
  } dmpc_cyc_s;
endpackage : dmpc_pkg
`default_nettype wire

// ### dmpc_pwr_cycle.sv
// Periodic power cycling of the rf front end
`default_nettype none
`include "dmpc_defs.svh"
module dmpc_pwr_cycle
  import dmpc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_en,
  input wire logic i_ms_tick,
  input wire logic [15:0] i_on_interval_ms,
  input wire logic [6:0] i_on_fraction,
  input wire logic i_nav_done,
  output logic o_rf_pwr,
  output logic o_cpu_awake,
  output logic o_rtc_wake
);
  dmpc_cyc_s q, d;
  logic [6:0] pct;
  logic [6:0] rem;
  logic [23:0] tgt;
  logic off_done;

  // Off time is never divided out: the off phase ends once the sum of
  // the fraction over elapsed ms reaches on * (100 - fraction)
  always_comb begin
    if (i_on_fraction == 7'h00) begin
      pct = 7'h01;
    end else if (i_on_fraction > `DMPC_PCT_FULL) begin
      pct = `DMPC_PCT_FULL;
    end else begin
      pct = i_on_fraction;
    end
    rem = 7'(`DMPC_PCT_FULL - pct);
    tgt = {8'h00, i_on_interval_ms} * {17'h00000, rem};
    off_done = (q.acc >= tgt);
  end

  always_comb begin
    d = q;
    d.wake = 1'b0;
    if (!i_en) begin
      d = '{st: CYC_ON, ms_cnt: 16'h0000, acc: 24'h000000,
            rf: 1'b1, awake: 1'b1, wake: 1'b0};
    end else begin
      if (q.st != CYC_ON && i_ms_tick) begin
        d.acc = 24'(q.acc + {17'h00000, pct});
      end
      unique case (q.st)
        CYC_ON: begin
          if (i_ms_tick) begin
            d.ms_cnt = 16'(q.ms_cnt + 16'h0001);
            if (d.ms_cnt >= i_on_interval_ms) begin
              d.st = CYC_NAV;
              d.rf = 1'b0;
              d.ms_cnt = 16'h0000;
              d.acc = 24'h000000;
            end
          end
        end
        CYC_NAV: begin
          if (off_done) begin
            d.st = CYC_ON;
            d.rf = 1'b1;
            d.wake = 1'b1;
          end else if (i_nav_done) begin
            d.st = CYC_SLEEP;
            d.awake = 1'b0;
          end
        end
        CYC_SLEEP: begin
          if (off_done) begin
            d.st = CYC_ON;
            d.rf = 1'b1;
            d.awake = 1'b1;
            d.wake = 1'b1;
          end
        end
        default: begin
          d.st = CYC_ON;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '{st: CYC_ON, ms_cnt: 16'h0000, acc: 24'h000000,
             rf: 1'b1, awake: 1'b1, wake: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign o_rf_pwr = q.rf;
  assign o_cpu_awake = q.awake;
  assign o_rtc_wake = q.wake;

  wake_restores_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    o_rtc_wake |-> o_rf_pwr && o_cpu_awake)
    else $error("rtc wake without power restored");
  sleep_after_nav_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_en && q.st == CYC_NAV && i_nav_done && !off_done |=> !o_cpu_awake)
    else $error("cpu stays awake after nav done");
endmodule : dmpc_pwr_cycle
`default_nettype wire

// ### dmpc_tick.sv
// Free running divider giving a one-cycle enable pulse
`default_nettype none
module dmpc_tick #(
  parameter int unsigned CYC = 100_000
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  output logic o_tick
);
  localparam int unsigned W = $clog2(CYC + 1);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } dmpc_tick_s;
  dmpc_tick_s q, d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == W'(CYC - 1)) begin
      d.cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = W'(q.cnt + 1'b1);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_tick = q.tick;
endmodule : dmpc_tick
`default_nettype wire

// ### dmpc_top.sv
// Discrete monitor, periodic power cycler and triggered-fix sequencer
`default_nettype none
`include "dmpc_defs.svh"
module dmpc_top
  import dmpc_pkg::*;
#(
  parameter int unsigned SEC_CYC = `DMPC_SEC_CYC,
  parameter int unsigned MS_CYC = `DMPC_MS_CYC,
  parameter int unsigned FIX_ACT_S = `DMPC_FIX_ACT_S,
  parameter int unsigned REFRESH_S = `DMPC_REFRESH_S
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [4:0] i_disc_lvl,
  input wire logic [4:0] i_disc_dir_out,
  input wire logic [4:0] i_disc_out_val,
  input wire logic i_fifth_en,
  input wire logic i_custom_logging_protocol,
  input wire logic i_pps,
  input wire logic i_periodic_power_cycling,
  input wire logic [15:0] i_on_interval_ms,
  input wire logic [6:0] i_on_fraction,
  input wire logic i_nav_done,
  input wire logic i_triggered_fix_mode,
  input wire logic i_fix_trig_n,
  input wire logic i_eph_valid,
  input wire logic i_pos_valid,
  output logic [4:0] o_disc_pu_en,
  output logic [4:0] o_disc_o,
  output logic [4:0] o_disc_oe,
  output logic o_pps,
  output logic o_check_stb,
  output logic o_log_req,
  output logic [4:0] o_log_disc,
  output logic o_rf_pwr,
  output logic o_cpu_awake,
  output logic o_rtc_pwr,
  output logic o_msg_en
);
  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    dmpc_fix_st_e st;
    logic [15:0] sec_cnt;
    logic trig_prev;
    logic [4:0] ref_lvl;
    logic ref_vld;
    logic log_req;
    logic [4:0] log_disc;
    logic chk;
    logic pps;
    logic [4:0] oe;
    logic [4:0] dout;
    logic [4:0] pu;
    logic rf;
    logic awake;
    logic msg;
    logic rtc;
  } dmpc_top_s;

  dmpc_top_s q, d;
  logic sec_tick;
  logic ms_tick;
  logic cyc_rf;
  logic cyc_awake;
  logic [4:0] samp;
  logic [4:0] oe_c;
  logic trig_fall;
  logic fix_active;

  // --------------------------------------------------------------------
  // Time bases
  // --------------------------------------------------------------------
  dmpc_tick #(.CYC(SEC_CYC)) u_sec_tick (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .o_tick(sec_tick)
  );

  dmpc_tick #(.CYC(MS_CYC)) u_ms_tick (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .o_tick(ms_tick)
  );

  dmpc_pwr_cycle u_pwr_cycle (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_en(i_periodic_power_cycling),
    .i_ms_tick(ms_tick),
    .i_on_interval_ms(i_on_interval_ms),
    .i_on_fraction(i_on_fraction),
    .i_nav_done(i_nav_done),
    .o_rf_pwr(cyc_rf),
    .o_cpu_awake(cyc_awake),
    .o_rtc_wake()
  );

  // --------------------------------------------------------------------
  // Per-line direction and sampling
  // --------------------------------------------------------------------
  for (genvar i = 0; i < `DMPC_NLINES; i++) begin : g_line
    if (i == `DMPC_RSVD_IDX) begin : g_rsvd
      // Reserved line: never driven, always logged Off
      assign oe_c[i] = 1'b0;
      assign samp[i] = 1'b0;
    end else if (i == `DMPC_FIFTH_IDX) begin : g_fifth
      assign oe_c[i] = i_fifth_en & i_disc_dir_out[i]
                       & ~i_custom_logging_protocol;
      assign samp[i] = i_fifth_en & i_disc_lvl[i];
    end else begin : g_std
      assign oe_c[i] = i_disc_dir_out[i]
                       & ~i_custom_logging_protocol;
      // High or floating logs On, grounded logs Off; levels
      // shorter than a second may slip between samples
      assign samp[i] = i_disc_lvl[i];
    end
  end

  assign trig_fall = q.trig_prev & ~i_fix_trig_n;
  assign fix_active = (q.st != FIX_SLEEP);

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    d = q;
    d.log_req = 1'b0;
    d.chk = sec_tick;
    d.trig_prev = i_fix_trig_n;
    d.oe = oe_c;
    d.dout = i_disc_out_val & oe_c;
    d.pu = ~oe_c;
    d.pps = i_pps & ~i_fifth_en;
    d.rtc = 1'b1;

    // Changes are seen only at the second tick, never on an edge
    if (sec_tick) begin
      d.ref_lvl = samp;
      d.ref_vld = 1'b1;
      if (q.ref_vld && i_custom_logging_protocol
          && samp != q.ref_lvl) begin
        d.log_req = 1'b1;
        d.log_disc = samp;
      end
    end

    if (!i_triggered_fix_mode) begin
      d.st = FIX_ACQ;
      d.sec_cnt = 16'h0000;
    end else begin
      unique case (q.st)
        FIX_ACQ: begin
          if (i_eph_valid && i_pos_valid) begin
            d.st = FIX_SLEEP;
            d.sec_cnt = 16'h0000;
          end
        end
        FIX_SLEEP: begin
          if (trig_fall) begin
            d.st = FIX_TRIG;
            d.sec_cnt = 16'h0000;
          end else if (sec_tick) begin
            d.sec_cnt = 16'(q.sec_cnt + 16'h0001);
            if (d.sec_cnt >= 16'(REFRESH_S)) begin
              d.st = FIX_REFR;
              d.sec_cnt = 16'h0000;
            end
          end
        end
        FIX_REFR: begin
          if (trig_fall) begin
            d.st = FIX_TRIG;
            d.sec_cnt = 16'h0000;
          end else if (i_eph_valid && i_pos_valid) begin
            d.st = FIX_SLEEP;
          end
        end
        FIX_TRIG: begin
          // A fresh trigger here is ignored on purpose
          if (sec_tick) begin
            d.sec_cnt = 16'(q.sec_cnt + 16'h0001);
            if (d.sec_cnt >= 16'(FIX_ACT_S)) begin
              d.st = FIX_SLEEP;
              d.sec_cnt = 16'h0000;
            end
          end
        end
        default: begin
          d.st = FIX_ACQ;
        end
      endcase
    end

    // Triggered fix wins over cycling; neither means always powered
    if (i_triggered_fix_mode) begin
      d.rf = fix_active;
      d.awake = fix_active;
      d.msg = fix_active;
    end else if (i_periodic_power_cycling) begin
      d.rf = cyc_rf;
      d.awake = cyc_awake;
      d.msg = cyc_awake;
    end else begin
      d.rf = 1'b1;
      d.awake = 1'b1;
      d.msg = 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '{st: FIX_ACQ, sec_cnt: 16'h0000, trig_prev: 1'b1,
             ref_lvl: 5'h00, ref_vld: 1'b0, log_req: 1'b0,
             log_disc: 5'h00, chk: 1'b0, pps: 1'b0, oe: 5'h00,
             dout: 5'h00, pu: 5'h1f, rf: 1'b1, awake: 1'b1,
             msg: 1'b1, rtc: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign o_disc_pu_en = q.pu;
  assign o_disc_o = q.dout;
  assign o_disc_oe = q.oe;
  assign o_pps = q.pps;
  assign o_check_stb = q.chk;
  assign o_log_req = q.log_req;
  assign o_log_disc = q.log_disc;
  assign o_rf_pwr = q.rf;
  assign o_cpu_awake = q.awake;
  assign o_rtc_pwr = q.rtc;
  assign o_msg_en = q.msg;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  log_on_change_a: assert property (
    sec_tick && q.ref_vld && i_custom_logging_protocol
    && samp != q.ref_lvl |=> o_log_req && o_log_disc == $past(samp))
    else $error("level change not logged");
  log_tick_only_a: assert property (
    o_log_req |-> $past(sec_tick) && !$past(o_log_req))
    else $error("log request off the second tick");
  rsvd_line_off_a: assert property (
    o_log_req |-> !o_log_disc[`DMPC_RSVD_IDX])
    else $error("reserved line logged On");
  ref_store_a: assert property (
    sec_tick |=> q.ref_lvl == $past(samp) && q.ref_vld)
    else $error("reference not stored");
  pps_gate_a: assert property (
    $past(i_fifth_en) |-> !o_pps)
    else $error("pps driven with fifth line");
  std_inputs_a: assert property (
    $past(i_custom_logging_protocol) |-> o_disc_oe == 5'h00)
    else $error("logging line driven as output");
  pullup_a: assert property (
    o_disc_pu_en == ~o_disc_oe)
    else $error("undriven line without pull-up");
  check_stb_a: assert property (
    sec_tick |=> o_check_stb ##1 !o_check_stb)
    else $error("second check strobe wrong");
  trig_hold_a: assert property (
    i_triggered_fix_mode && q.st == FIX_TRIG && trig_fall && !sec_tick
    |=> q.st == FIX_TRIG && q.sec_cnt == $past(q.sec_cnt))
    else $error("trigger restarted active period");
  trig_bound_a: assert property (
    q.st == FIX_TRIG |-> q.sec_cnt < 16'(FIX_ACT_S))
    else $error("triggered active period overran");
  trig_start_a: assert property (
    i_triggered_fix_mode && q.st == FIX_SLEEP && trig_fall
    |=> q.st == FIX_TRIG ##1 o_rf_pwr && o_msg_en)
    else $error("trigger did not power up");
  fix_sleep_a: assert property (
    i_triggered_fix_mode && q.st == FIX_ACQ && i_eph_valid && i_pos_valid
    |=> ##1 !o_rf_pwr && !o_cpu_awake)
    else $error("no sleep after first fix");

  log_seen_c: cover property (o_log_req);
  trig_seen_c: cover property (q.st == FIX_TRIG ##1 q.st == FIX_SLEEP);
  cyc_off_c: cover property (i_periodic_power_cycling && !o_rf_pwr);
  refresh_c: cover property (q.st == FIX_REFR);
endmodule : dmpc_top
`default_nettype wire

// ### tb.sv
// Self-checking bench for the discrete monitor and power cycler
`default_nettype none
`include "dmpc_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // Set-up
  // ------------------------------------------------------------------
  // Short counts keep the run small; expectations derive from these
  localparam int SEC = 100;
  localparam int MS = 10;
  localparam int ACT = 3;
  localparam int REF = 5;
  localparam int LIMIT = 40000;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [4:0] lvl, dir_out = 5'h00, out_val = 5'h00, closed = 5'h00;
  logic fifth = 1'h0, logc = 1'h1, pps = 1'h0, cyc = 1'h0, nav = 1'h0;
  logic fixm = 1'h0, trig_n, eph = 1'h1, pos = 1'h1, press = 1'h0;
  logic [15:0] on_ms = 16'h0001;
  logic [6:0] frac = 7'h64;
  logic [4:0] pu, dout, oe, log_disc;
  logic pps_o, stb, log_req, rf, awake, rtc, msg;
  int n_errors = 0;
  int checks_done = 0;
  int n_cyc = 0;

  dmpc_top #(.SEC_CYC(SEC), .MS_CYC(MS), .FIX_ACT_S(ACT), .REFRESH_S(REF))
    uut (.i_clk(clk), .i_sys_rst(rst), .i_disc_lvl(lvl),
    .i_disc_dir_out(dir_out), .i_disc_out_val(out_val), .i_fifth_en(fifth),
    .i_custom_logging_protocol(logc), .i_pps(pps),
    .i_periodic_power_cycling(cyc), .i_on_interval_ms(on_ms),
    .i_on_fraction(frac), .i_nav_done(nav), .i_triggered_fix_mode(fixm),
    .i_fix_trig_n(trig_n), .i_eph_valid(eph), .i_pos_valid(pos),
    .o_disc_pu_en(pu), .o_disc_o(dout), .o_disc_oe(oe), .o_pps(pps_o),
    .o_check_stb(stb), .o_log_req(log_req), .o_log_disc(log_disc),
    .o_rf_pwr(rf), .o_cpu_awake(awake), .o_rtc_pwr(rtc), .o_msg_en(msg));

  dmpc_contacts far_side (.i_clk(clk), .i_closed(closed), .i_press(press),
    .i_pu_en(pu), .i_o(dout), .i_oe(oe), .o_lvl(lvl), .o_trig_n(trig_n));

  initial begin
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Returns just after the edge that shows the once-a-second strobe
  task automatic wait_stb;
    int k;
    tick(1);
    for (k = 0; k < 2 * SEC && stb !== 1'h1; k++) tick(1);
    chk(stb, 1'h1);
  endtask : wait_stb

  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    tick(2);
    chk(pu, 5'h1f);
    chk(rtc, 1'h1);
    chk(oe, 5'h00);
    chk(stb, 1'h0);
    $display("reset test done");
  endtask : t_reset

  // Every level is held for a full second except the deliberate glitch
  task automatic t_log;
    wait_stb();
    chk(log_req, 1'h0);
    @(posedge clk);
    closed <= 5'h01;
    wait_stb();
    chk(log_req, 1'h1);
    chk(log_disc, 5'h0a);
    @(posedge clk);
    closed <= 5'h05;
    wait_stb();
    chk(log_req, 1'h0);
    repeat (20) @(posedge clk);
    closed <= 5'h07;
    repeat (30) @(posedge clk);
    closed <= 5'h05;
    wait_stb();
    chk(log_req, 1'h0);
    @(posedge clk);
    closed <= 5'h00;
    wait_stb();
    chk(log_req, 1'h1);
    chk(log_disc, 5'h0b);
    wait_stb();
    chk(log_req, 1'h0);
    $display("logging test done");
  endtask : t_log

  task automatic t_lines;
    @(posedge clk);
    logc <= 1'h0;
    dir_out <= 5'h0f;
    out_val <= 5'h15;
    tick(3);
    chk(oe, 5'h0b);
    chk(dout, 5'h01);
    chk(pu, 5'h14);
    @(posedge clk);
    logc <= 1'h1;
    pps <= 1'h1;
    tick(3);
    chk(oe, 5'h00);
    chk(pps_o, 1'h1);
    @(posedge clk);
    fifth <= 1'h1;
    tick(3);
    chk(pps_o, 1'h0);
    @(posedge clk);
    fifth <= 1'h0;
    dir_out <= 5'h00;
    pps <= 1'h0;
    $display("line setup test done");
  endtask : t_lines

  task automatic t_cycle(input int on, input int f);
    int k, off;
    longint t0, t1, t2;
    off = (on * (100 - f) + f - 1) / f;
    @(posedge clk);
    cyc <= 1'h0;
    on_ms <= 16'(on);
    frac <= 7'(f);
    @(posedge clk);
    cyc <= 1'h1;
    tick(2);
    for (k = 0; k < 400 * MS && rf !== 1'h0; k++) tick(1);
    t0 = $time;
    tick(3);
    chk(awake, 1'h1);
    chk(rtc, 1'h1);
    @(posedge clk);
    nav <= 1'h1;
    @(posedge clk);
    nav <= 1'h0;
    tick(2);
    chk(awake, 1'h0);
    for (k = 0; k < 900 * MS && rf !== 1'h1; k++) tick(1);
    t1 = $time;
    chk(awake, 1'h1);
    for (k = 0; k < 400 * MS && rf !== 1'h0; k++) tick(1);
    t2 = $time;
    chk(16'(((t1 - t0) / 10 + MS / 2) / MS), 16'(off));
    chk(16'(((t2 - t1) / 10 + MS / 2) / MS), 16'(on));
    $display("cycling test done");
  endtask : t_cycle

  task automatic t_fix;
    int k;
    longint len, t0;
    @(posedge clk);
    cyc <= 1'h0;
    fixm <= 1'h1;
    eph <= 1'h0;
    tick(4);
    chk(awake, 1'h1);
    @(posedge clk);
    eph <= 1'h1;
    tick(4);
    chk(rf, 1'h0);
    chk(rtc, 1'h1);
    t0 = $time;
    @(posedge clk);
    press <= 1'h1;
    tick(4);
    chk(rf, 1'h1);
    chk(msg, 1'h1);
    repeat (40) @(posedge clk);
    press <= 1'h0;
    repeat (40) @(posedge clk);
    press <= 1'h1;
    for (k = 0; k < (ACT + 2) * SEC && rf !== 1'h0; k++) tick(1);
    len = ($time - t0) / 10;
    chk(16'(len >= (ACT - 1) * SEC), 16'h1);
    chk(16'(len <= ACT * SEC + 6), 16'h1);
    chk(msg, 1'h0);
    @(posedge clk);
    press <= 1'h0;
    eph <= 1'h0;
    tick(2);
    for (k = 0; k < (REF + 2) * SEC && rf !== 1'h1; k++) tick(1);
    chk(rf, 1'h1);
    @(posedge clk);
    eph <= 1'h1;
    tick(4);
    chk(rf, 1'h0);
    $display("triggered fix test done");
  endtask : t_fix

  // ------------------------------------------------------------------
  // Main sequence and hang guard
  // ------------------------------------------------------------------
  initial begin
    t_reset();
    t_log();
    t_lines();
    t_cycle(3, 40);
    t_cycle(`DMPC_ON_MS_TYP, `DMPC_FRAC_TYP);
    t_fix();
    close_out();
  end

  always @(posedge clk) begin
    n_cyc <= n_cyc + 1;
    if (n_cyc == LIMIT) begin
      n_errors++;
      close_out();
    end
  end
endmodule : tb
`default_nettype wire
